// file: rtl/irc_pkg.sv
// Purpose: shared constants and types for the rate converter control registers
// Assumes: 32-bit apb data, registers at byte address four times their index
// Notes: none
package irc_pkg;
    // ----------------------------------------------------------------
    // register indices and byte address width
    // ----------------------------------------------------------------
    localparam logic [11:0] CONV1_HIGH_RATE_CTRL_IDX = 12'hef0;
    localparam logic [11:0] CONV1_LOW_RATE_CTRL_IDX = 12'hef1;
    localparam logic [11:0] CONV1_PATH_ENABLES_IDX = 12'hef2;
    localparam logic [11:0] CONV2_HIGH_RATE_CTRL_IDX = 12'hef3;
    localparam logic [11:0] PATH_REFUSED_IDX = 12'hef8;
    localparam logic [11:0] CLOCK_BUDGET_IDX = 12'hef9;
    localparam int ADDR_W = 14;

    // ----------------------------------------------------------------
    // field layout and reset values
    // ----------------------------------------------------------------
    localparam int RATE_SEL_LSB = 11;
    localparam int RATE_SEL_MSB = 14;
    localparam int UP_EN_LSB = 12;
    localparam int UP_EN_MSB = 15;
    localparam int DOWN_EN_LSB = 6;
    localparam int DOWN_EN_MSB = 9;
    localparam logic [3:0] RATE_SEL_RST = 4'h0;
    localparam logic [3:0] PATH_EN_RST = 4'h0;
    localparam logic [7:0] CLOCK_BUDGET_RST = 8'hff;

    // ----------------------------------------------------------------
    // rate select code table
    // ----------------------------------------------------------------
    localparam logic [3:0] RATE_SYS_ONE = 4'h0;
    localparam logic [3:0] RATE_SYS_TWO = 4'h1;
    localparam logic [3:0] RATE_SYS_THREE = 4'h2;
    localparam logic [3:0] RATE_ASYNC_ONE = 4'h8;
    localparam logic [3:0] RATE_ASYNC_TWO = 4'h9;

    typedef enum logic [2:0] {
        IRC_RATE_SYS1 = 3'b000,
        IRC_RATE_SYS2 = 3'b001,
        IRC_RATE_SYS3 = 3'b010,
        IRC_RATE_ASYNC1 = 3'b100,
        IRC_RATE_ASYNC2 = 3'b101,
        IRC_RATE_RSVD = 3'b111
    } irc_rate_t;

    typedef struct packed {
        logic [3:0] conv1_high_rate_sel;
        logic [3:0] conv1_low_rate_sel;
        logic [3:0] conv1_upsample_path_en;
        logic [3:0] conv1_downsample_path_en;
        logic [3:0] conv2_high_rate_sel;
    } irc_ctrl_t;

    // ----------------------------------------------------------------
    // software wait between selector clear and rate change
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int RATE_CHANGE_WAIT_US = 125;
    localparam int RATE_CHANGE_WAIT_CYC = RATE_CHANGE_WAIT_US * CLK_MHZ;
endpackage : irc_pkg

// file: rtl/irc_rate_decode.sv
// Purpose: decode one 4-bit rate select code into rate and clock domain
// Assumes: codes follow the shared rate table
// Notes: purely combinational
`timescale 1ns/1ns
module irc_rate_decode (
    input wire logic [3:0] code, // rate select field
    output irc_pkg::irc_rate_t rate, // decoded rate
    output logic async_dom, // 1 when rate is on the async clock
    output logic reserved // 1 for a reserved code
);
    always_comb begin
        case (code)
            irc_pkg::RATE_SYS_ONE: rate = irc_pkg::IRC_RATE_SYS1;
            irc_pkg::RATE_SYS_TWO: rate = irc_pkg::IRC_RATE_SYS2;
            irc_pkg::RATE_SYS_THREE: rate = irc_pkg::IRC_RATE_SYS3;
            irc_pkg::RATE_ASYNC_ONE: rate = irc_pkg::IRC_RATE_ASYNC1;
            irc_pkg::RATE_ASYNC_TWO: rate = irc_pkg::IRC_RATE_ASYNC2;
            default: rate = irc_pkg::IRC_RATE_RSVD;
        endcase
    end

    assign async_dom = rate[2];
    assign reserved = (rate == irc_pkg::IRC_RATE_RSVD);
endmodule // irc_rate_decode

// file: rtl/irc_regs.sv
// Purpose: apb register bank steering the isochronous rate converters
// Assumes: apb slave, zero wait states, 32-bit data, word per register
// Notes: path enables are gated by a clock budget supplied by the clock monitor
`timescale 1ns/1ns
module irc_regs #(
    parameter int PATHS = 4, // paths per direction
    parameter int BUDGET_W = 8 // width of cycle budget counts
) (
    input wire logic pclk, // apb clock
    input wire logic presetn, // async active-low reset
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [irc_pkg::ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    output logic pready, // apb ready, always one
    output logic [31:0] prdata, // apb read data
    output logic pslverr, // apb error on unmapped access
    input wire logic [BUDGET_W-1:0] sys_cycles_free, // spare core cycles
    input wire logic [BUDGET_W-1:0] async_cycles_free, // spare async cycles
    output irc_pkg::irc_ctrl_t ctrl, // fields to the converters
    output logic conv1_async_dom, // converter one runs on async clock
    output logic conv1_rate_reserved // a converter one field holds reserved code
);
    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    function automatic logic [irc_pkg::ADDR_W-1:0] byte_addr(input logic [11:0] idx);
        byte_addr = {idx, 2'b00};
    endfunction

    logic access;
    logic wr_en;
    logic hit_h1, hit_l1, hit_en1, hit_h2, hit_ref, hit_bud, mapped;
    logic lane1_we;
    logic [15:0] wdata16;

    assign access = psel && penable;
    assign hit_h1 = (paddr == byte_addr(irc_pkg::CONV1_HIGH_RATE_CTRL_IDX));
    assign hit_l1 = (paddr == byte_addr(irc_pkg::CONV1_LOW_RATE_CTRL_IDX));
    assign hit_en1 = (paddr == byte_addr(irc_pkg::CONV1_PATH_ENABLES_IDX));
    assign hit_h2 = (paddr == byte_addr(irc_pkg::CONV2_HIGH_RATE_CTRL_IDX));
    assign hit_ref = (paddr == byte_addr(irc_pkg::PATH_REFUSED_IDX));
    assign hit_bud = (paddr == byte_addr(irc_pkg::CLOCK_BUDGET_IDX));
    assign mapped = hit_h1 | hit_l1 | hit_en1 | hit_h2 | hit_ref | hit_bud;
    assign wr_en = access && pwrite && mapped;
    // every field lives in bits 15:0, so only byte lanes 0 and 1 matter
    assign lane1_we = pstrb[1];
    assign wdata16 = pwdata[15:0];
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // ----------------------------------------------------------------
    // rate select fields
    // ----------------------------------------------------------------
    logic [3:0] conv1_high_rate_sel_ff;
    logic [3:0] conv1_low_rate_sel_ff;
    logic [3:0] conv2_high_rate_sel_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            conv1_high_rate_sel_ff <= irc_pkg::RATE_SEL_RST;
            conv1_low_rate_sel_ff <= irc_pkg::RATE_SEL_RST;
            conv2_high_rate_sel_ff <= irc_pkg::RATE_SEL_RST;
        end else if (wr_en && lane1_we) begin
            // bits 14:11 sit wholly in lane 1, so only pstrb[1] gates the write
            if (hit_h1) begin
                conv1_high_rate_sel_ff <= wdata16[irc_pkg::RATE_SEL_MSB:irc_pkg::RATE_SEL_LSB];
            end
            if (hit_l1) begin
                conv1_low_rate_sel_ff <= wdata16[irc_pkg::RATE_SEL_MSB:irc_pkg::RATE_SEL_LSB];
            end
            if (hit_h2) begin
                conv2_high_rate_sel_ff <= wdata16[irc_pkg::RATE_SEL_MSB:irc_pkg::RATE_SEL_LSB];
            end
        end
    end

    // ----------------------------------------------------------------
    // clock budget: cycles one path needs, one value for both domains
    // ----------------------------------------------------------------
    logic [BUDGET_W-1:0] cost_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cost_ff <= BUDGET_W'(irc_pkg::CLOCK_BUDGET_RST);
        end else if (wr_en && hit_bud && pstrb[0]) begin
            cost_ff <= pwdata[BUDGET_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // path enables with underclock refusal
    // ----------------------------------------------------------------
    logic conv1_async;
    logic high_rsvd, low_rsvd;
    irc_pkg::irc_rate_t high_rate, low_rate;

    irc_rate_decode u_dec_high (
        .code(conv1_high_rate_sel_ff),
        .rate(high_rate),
        .async_dom(conv1_async),
        .reserved(high_rsvd)
    );

    irc_rate_decode u_dec_low (
        .code(conv1_low_rate_sel_ff),
        .rate(low_rate),
        .async_dom(),
        .reserved(low_rsvd)
    );

    function automatic logic [3:0] count_ones(input logic [2*PATHS-1:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 2 * PATHS; i++) begin
            n = n + {3'b000, v[i]};
        end
        count_ones = n;
    endfunction

    logic [PATHS-1:0] up_en_ff, down_en_ff;
    logic [PATHS-1:0] nxt_up_en, nxt_down_en;
    logic [2*PATHS-1:0] refused_ff;
    logic [2*PATHS-1:0] req, active, newly, granted;
    logic [BUDGET_W-1:0] avail;
    logic [BUDGET_W+3:0] used;

    assign avail = conv1_async ? async_cycles_free : sys_cycles_free;
    assign req = {wdata16[irc_pkg::UP_EN_MSB:irc_pkg::UP_EN_LSB],
                  wdata16[irc_pkg::DOWN_EN_MSB:irc_pkg::DOWN_EN_LSB]};
    assign active = {up_en_ff, down_en_ff};
    assign newly = req & ~active;

    // new paths are granted in priority from bit 15 down; each takes cost_ff cycles
    always_comb begin
        granted = '0;
        used = '0;
        for (int i = 2 * PATHS - 1; i >= 0; i--) begin
            if (newly[i] && (used + {4'h0, cost_ff}) <= {4'h0, avail}) begin
                granted[i] = 1'b1;
                used = used + {4'h0, cost_ff};
            end
        end
    end

    always_comb begin
        nxt_up_en = up_en_ff;
        nxt_down_en = down_en_ff;
        if (wr_en && hit_en1) begin
            // clearing always allowed; already active paths stay untouched
            if (pstrb[1]) begin
                nxt_up_en = (req[2*PATHS-1:PATHS] & up_en_ff) | granted[2*PATHS-1:PATHS];
            end
            if (pstrb[1] || pstrb[0]) begin
                nxt_down_en = (req[PATHS-1:0] & down_en_ff) | granted[PATHS-1:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_en_ff <= irc_pkg::PATH_EN_RST;
            down_en_ff <= irc_pkg::PATH_EN_RST;
        end else begin
            up_en_ff <= nxt_up_en;
            down_en_ff <= nxt_down_en;
        end
    end

    // sticky record of refused enables; a refusal in the clear cycle wins
    logic [2*PATHS-1:0] refuse_now;
    assign refuse_now = (wr_en && hit_en1) ? (newly & ~granted) : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            refused_ff <= '0;
        end else begin
            if (wr_en && hit_ref && pstrb[0]) begin
                refused_ff <= (refused_ff & ~pwdata[2*PATHS-1:0]) | refuse_now;
            end else begin
                refused_ff <= refused_ff | refuse_now;
            end
        end
    end

    // ----------------------------------------------------------------
    // read back
    // ----------------------------------------------------------------
    function automatic logic [31:0] rate_word(input logic [3:0] sel);
        rate_word = {17'h00000, sel, 11'h000};
    endfunction

    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_h1) rd_mux = rate_word(conv1_high_rate_sel_ff);
        if (hit_l1) rd_mux = rate_word(conv1_low_rate_sel_ff);
        if (hit_h2) rd_mux = rate_word(conv2_high_rate_sel_ff);
        if (hit_en1) rd_mux = {16'h0000, up_en_ff, 2'b00, down_en_ff, 6'h00};
        if (hit_ref) rd_mux = {24'h000000, refused_ff};
        if (hit_bud) rd_mux = {{(32-BUDGET_W){1'b0}}, cost_ff};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end

    assign ctrl = '{conv1_high_rate_sel: conv1_high_rate_sel_ff,
                    conv1_low_rate_sel: conv1_low_rate_sel_ff,
                    conv1_upsample_path_en: up_en_ff,
                    conv1_downsample_path_en: down_en_ff,
                    conv2_high_rate_sel: conv2_high_rate_sel_ff};
    assign conv1_async_dom = conv1_async;
    assign conv1_rate_reserved = high_rsvd | low_rsvd | (high_rate == irc_pkg::IRC_RATE_RSVD)
                                 | (low_rate == irc_pkg::IRC_RATE_RSVD);
endmodule // irc_regs

// file: sim/irc_regs_checker.sv
// Purpose: concurrent checks on the rate converter register bank ports
// Assumes: apb slave with zero wait states, addresses four times the index
// Notes: bound into every irc_regs instance
`timescale 1ns/1ns
module irc_regs_checker #(
    parameter int BUDGET_W = 8 // width of cycle budget counts
) (
    input wire logic pclk, // apb clock
    input wire logic presetn, // async active-low reset
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [irc_pkg::ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    input wire logic [3:0] pstrb, // apb byte strobes
    input wire logic [31:0] prdata, // apb read data
    input wire logic pslverr, // apb error
    input wire irc_pkg::irc_ctrl_t ctrl, // fields to the converters
    input wire logic conv1_async_dom, // converter one domain
    input wire logic conv1_rate_reserved // reserved code flag
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable;
    wire wr = acc && pwrite && pstrb[1];
    wire [3:0] wd = pwdata[14:11];
    wire mapped = paddr inside {14'h3bc0, 14'h3bc4, 14'h3bc8, 14'h3bcc, 14'h3be0, 14'h3be4};
    function automatic logic rsv(input logic [3:0] c);
        return !(c inside {4'h0, 4'h1, 4'h2, 4'h8, 4'h9});
    endfunction

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    AST_UNMAPPED: assert property (acc && !mapped |-> pslverr && (pwrite || prdata == 32'h0))
        else $error("unmapped access not refused");
    AST_HIGH_WR: assert property (wr && paddr == 14'h3bc0 |=> ctrl.conv1_high_rate_sel == $past(wd))
        else $error("high rate field not written");
    AST_LOW_WR: assert property (wr && paddr == 14'h3bc4 |=> ctrl.conv1_low_rate_sel == $past(wd))
        else $error("low rate field not written");
    AST_CONV2_WR: assert property (wr && paddr == 14'h3bcc |=> ctrl.conv2_high_rate_sel == $past(wd))
        else $error("second converter field not written");
    AST_HOLD: assert property (!(acc && pwrite) |=> $stable(ctrl))
        else $error("fields changed without a write");
    // reserved codes decode onto the async side
    AST_DOM: assert property (conv1_async_dom ==
        (ctrl.conv1_high_rate_sel[3] || rsv(ctrl.conv1_high_rate_sel)))
        else $error("domain flag wrong");
    AST_RSVD: assert property (conv1_rate_reserved ==
        (rsv(ctrl.conv1_high_rate_sel) || rsv(ctrl.conv1_low_rate_sel)))
        else $error("reserved flag wrong");
    AST_UP_GRANT: assert property (wr && paddr == 14'h3bc8 |=>
        (ctrl.conv1_upsample_path_en & ~$past(pwdata[15:12])) == 4'h0 &&
        ($past(ctrl.conv1_upsample_path_en) & $past(pwdata[15:12]) & ~ctrl.conv1_upsample_path_en) == 4'h0)
        else $error("upsample enable grant wrong");
    AST_DN_GRANT: assert property (wr && paddr == 14'h3bc8 |=>
        (ctrl.conv1_downsample_path_en & ~$past(pwdata[9:6])) == 4'h0 &&
        ($past(ctrl.conv1_downsample_path_en) & $past(pwdata[9:6]) & ~ctrl.conv1_downsample_path_en) == 4'h0)
        else $error("downsample enable grant wrong");
    AST_RD_MASK: assert property (acc && !pwrite && paddr == 14'h3bc0 |->
        prdata[31:15] == 17'h0 && prdata[10:0] == 11'h0)
        else $error("unused bits read nonzero");
    cover property (wr && paddr == 14'h3bc8);
    cover property (acc && !mapped);
    cover property (acc && !pwrite && paddr == 14'h3bc0);
endmodule // irc_regs_checker

bind irc_regs irc_regs_checker #(.BUDGET_W(BUDGET_W)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pslverr(pslverr), .ctrl(ctrl),
    .conv1_async_dom(conv1_async_dom), .conv1_rate_reserved(conv1_rate_reserved));

// file: sim/irc_regs_tb_top.sv
// Purpose: self-checking bench for the rate converter register bank
// Assumes: zero wait state slave, but every wait is bounded anyway
// Notes: strobes stay full so every lane reaches the registers
`timescale 1ns/1ns
module irc_regs_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dom, rsv, e;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [3:0] pstrb;
    logic [7:0] sysf, asyf;
    irc_pkg::irc_ctrl_t ctrl;
    int failures, samples_checked;
    localparam logic [13:0] A_HI = {irc_pkg::CONV1_HIGH_RATE_CTRL_IDX, 2'b00};
    localparam logic [13:0] A_LO = {irc_pkg::CONV1_LOW_RATE_CTRL_IDX, 2'b00};
    localparam logic [13:0] A_EN = {irc_pkg::CONV1_PATH_ENABLES_IDX, 2'b00};
    localparam logic [13:0] A_C2 = {irc_pkg::CONV2_HIGH_RATE_CTRL_IDX, 2'b00};
    localparam logic [13:0] A_REF = {irc_pkg::PATH_REFUSED_IDX, 2'b00};
    localparam logic [13:0] A_COST = {irc_pkg::CLOCK_BUDGET_IDX, 2'b00};

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    irc_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .sys_cycles_free(sysf), .async_cycles_free(asyf),
        .ctrl(ctrl), .conv1_async_dom(dom), .conv1_rate_reserved(rsv));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic conclude();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one apb transfer; pready is sampled at the edge, never assumed
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            failures++;
            conclude();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdc(input logic [13:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(r, x);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rdc(A_HI, 32'h0);
        rdc(A_LO, 32'h0);
        rdc(A_EN, 32'h0);
        rdc(A_C2, 32'h0);
        rdc(A_COST, 32'hff);
        chk({31'h0, pready}, 32'h1);
        $display("t_reset done");
    endtask

    task automatic t_codes();
        for (int c = 0; c < 16; c++) begin
            apb(1'b1, A_HI, 32'(c) << 11);
            apb(1'b1, A_LO, 32'(c) << 11);
            apb(1'b1, A_C2, 32'(c) << 11);
            rdc(A_HI, 32'(c) << 11);
            rdc(A_LO, 32'(c) << 11);
            rdc(A_C2, 32'(c) << 11);
            chk({31'h0, dom}, {31'h0, c[3] || !(c inside {0, 1, 2, 8, 9})});
            chk(32'(ctrl), {12'h000, c[3:0], c[3:0], 8'h00, c[3:0]});
            chk({31'h0, rsv}, {31'h0, !(c inside {0, 1, 2, 8, 9})});
        end
        $display("t_codes done");
    endtask

    // ones everywhere: only the documented fields may stick
    task automatic t_unused();
        apb(1'b1, A_COST, 32'h1);
        apb(1'b1, A_HI, 32'hffffffff);
        apb(1'b1, A_LO, 32'hffffffff);
        apb(1'b1, A_EN, 32'hffffffff);
        apb(1'b1, A_C2, 32'hffffffff);
        rdc(A_HI, 32'h7800);
        rdc(A_LO, 32'h7800);
        rdc(A_C2, 32'h7800);
        rdc(A_EN, 32'hf3c0);
        apb(1'b1, 14'h3bd0, 32'hffffffff);
        chk({31'h0, e}, 32'h1);
        rdc(14'h3bd0, 32'h0);
        chk({31'h0, e}, 32'h1);
        rdc(A_HI, 32'h7800);
        $display("t_unused done");
    endtask

    task automatic t_refuse();
        apb(1'b1, A_EN, 32'h0);
        apb(1'b1, A_HI, 32'h0);
        apb(1'b1, A_REF, 32'hff);
        apb(1'b1, A_COST, 32'h10);
        sysf <= 8'h30;
        apb(1'b1, A_EN, 32'hf3c0);
        rdc(A_EN, 32'he000);
        rdc(A_REF, 32'h1f);
        sysf <= 8'h00;
        apb(1'b1, A_EN, 32'hf3c0);
        rdc(A_EN, 32'he000);
        apb(1'b1, A_EN, 32'h0);
        rdc(A_EN, 32'h0);
        apb(1'b1, A_REF, 32'hff);
        rdc(A_REF, 32'h0);
        apb(1'b1, A_HI, 32'h4000);
        sysf <= 8'hff;
        asyf <= 8'h00;
        apb(1'b1, A_EN, 32'h40);
        rdc(A_EN, 32'h0);
        asyf <= 8'h10;
        apb(1'b1, A_EN, 32'h40);
        rdc(A_EN, 32'h40);
        $display("t_refuse done");
    endtask

    // software order: settle wait, then rate writes; selectors left by t_refuse (enables 32'h40) are not cleared first
    task automatic t_sequence();
        repeat (irc_pkg::RATE_CHANGE_WAIT_CYC) @(posedge pclk);
        apb(1'b1, A_HI, 32'(irc_pkg::RATE_SYS_THREE) << 11);
        apb(1'b1, A_LO, 32'(irc_pkg::RATE_SYS_ONE) << 11);
        rdc(A_HI, 32'h1000);
        rdc(A_LO, 32'h0);
        chk({31'h0, dom}, 32'h0);
        chk({31'h0, rsv}, 32'h0);
        $display("t_sequence done");
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 14'h0;
        pwdata = 32'h0;
        pstrb = 4'hf;
        sysf = 8'hff;
        asyf = 8'hff;
        failures = 0;
        samples_checked = 0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_codes();
        t_unused();
        t_refuse();
        t_sequence();
        conclude();
    end
endmodule // irc_regs_tb_top
